//--- logic/refresh_rate_monitor.sv
`timescale 1ns/100ps

module refresh_rate_monitor #(
   parameter int SETTLE_CYCLES = refresh_monitor_pkg::RESULT_SETTLE_CYCLES
) (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic RATE_PIN,
   input wire refresh_monitor_pkg::cmd_t CMD,
   input wire logic FULL_REFRESH,
   input wire logic [7:0] RD_ADDR,
   output logic [7:0] RD_DATA,
   input wire refresh_monitor_pkg::results_t LIVE_RESULTS,
   output refresh_monitor_pkg::results_t HELD_RESULTS,
   output logic RESULTS_VALID,
   output logic SNAPSHOT,
   output logic ACCUM_CLEAR,
   output logic LATCH_CONTROLS
);
   import refresh_monitor_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic sync1_q, sync2_q, prev_q;
   logic rise_ev, fall_ev;
   logic [3:0] edge_en_q, edge_en_d;
   logic rose_q, rose_d, fell_q, fell_d;
   logic keep_cmd, mon_wr;
   logic lim_full, lim_keep, snap_now, clear_now;
   logic [7:0] mon_value, rd_data_d;
   results_t held_q, held_d;
   logic [31:0] settle_q, settle_d;
   logic valid_q, valid_d;
   logic snap_q, clear_q, latch_q;

   // ----------------------------------------------------------------
   // Pin synchronizer and edge detect
   // ----------------------------------------------------------------
   // Two stages before any use, third stage only for edge compare
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= RATE_PIN;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // One-cycle events per synchronized edge
   assign rise_ev = sync2_q & ~prev_q;
   assign fall_ev = ~sync2_q & prev_q;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   // Keep refresh only as data-less Send Byte; data-bearing form ignored
   assign keep_cmd = CMD.valid & ~CMD.has_data & (CMD.code == REFRESH_KEEP_ACCUM_CMD_OFS);
   assign mon_wr = CMD.valid & CMD.has_data & (CMD.code == RATE_PIN_MONITOR_OFS);

   // ----------------------------------------------------------------
   // Monitor register
   // ----------------------------------------------------------------
   // Enables change only on a host write; flags set wins over clear
   always_comb begin
      edge_en_d = edge_en_q;
      if (mon_wr) begin
         edge_en_d = CMD.data[RISE_FULL_EN_BIT:FALL_KEEP_EN_BIT];
      end
      rose_d = (rose_q & ~FULL_REFRESH) | rise_ev;
      fell_d = (fell_q & ~FULL_REFRESH) | fall_ev;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         edge_en_q <= EDGE_EN_RESET;
         rose_q <= PIN_FLAG_RESET;
         fell_q <= PIN_FLAG_RESET;
      end else begin
         edge_en_q <= edge_en_d;
         rose_q <= rose_d;
         fell_q <= fell_d;
      end
   end

   // Live view of the register, bit 0 tied low
   always_comb begin
      mon_value = READ_DATA_RESET;
      mon_value[PIN_LEVEL_BIT] = sync2_q;
      mon_value[PIN_ROSE_FLAG_BIT] = rose_q;
      mon_value[PIN_FELL_FLAG_BIT] = fell_q;
      mon_value[RISE_FULL_EN_BIT:FALL_KEEP_EN_BIT] = edge_en_q;
      mon_value[UNUSED_BIT] = 1'b0;
   end

   // ----------------------------------------------------------------
   // Refresh arbitration
   // ----------------------------------------------------------------
   // Edge-triggered limited refreshes, full beats keep on the same edge
   always_comb begin
      lim_full = (rise_ev & edge_en_q[RISE_FULL_EN_BIT-1])
         | (fall_ev & edge_en_q[FALL_FULL_EN_BIT-1]);
      lim_keep = ((rise_ev & edge_en_q[RISE_KEEP_EN_BIT-1])
         | (fall_ev & edge_en_q[FALL_KEEP_EN_BIT-1])) & ~lim_full;
      snap_now = FULL_REFRESH | keep_cmd | lim_full | lim_keep;
      clear_now = FULL_REFRESH | lim_full;
   end

   // ----------------------------------------------------------------
   // Held results and settle timer
   // ----------------------------------------------------------------
   // Capture on any refresh, then hold; valid after the settle time
   always_comb begin
      held_d = held_q;
      settle_d = settle_q;
      valid_d = valid_q;
      if (snap_now) begin
         held_d = LIVE_RESULTS;
         settle_d = 32'(SETTLE_CYCLES);
         valid_d = 1'b0;
      end else if (settle_q != 32'h0000_0000) begin
         settle_d = settle_q - 32'h0000_0001;
         valid_d = (settle_q == 32'h0000_0001);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         held_q <= '0;
         settle_q <= 32'h0000_0000;
         valid_q <= 1'b0;
      end else begin
         held_q <= held_d;
         settle_q <= settle_d;
         valid_q <= valid_d;
      end
   end

   // ----------------------------------------------------------------
   // Output strobes and read data
   // ----------------------------------------------------------------
   // Control latching only on the full command, never on limited ones
   always_comb begin
      rd_data_d = READ_DATA_RESET;
      if (RD_ADDR == RATE_PIN_MONITOR_OFS) begin
         rd_data_d = mon_value;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         snap_q <= 1'b0;
         clear_q <= 1'b0;
         latch_q <= 1'b0;
         RD_DATA <= READ_DATA_RESET;
      end else begin
         snap_q <= snap_now;
         clear_q <= clear_now;
         latch_q <= FULL_REFRESH;
         RD_DATA <= rd_data_d;
      end
   end

   assign SNAPSHOT = snap_q;
   assign ACCUM_CLEAR = clear_q;
   assign LATCH_CONTROLS = latch_q;
   assign HELD_RESULTS = held_q;
   assign RESULTS_VALID = valid_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   // Level bit follows the pin two edges later
   AST_LEVEL_SYNC: assert property (##3 (mon_value[PIN_LEVEL_BIT] == $past(RATE_PIN, 2)))
      else $error("level bit does not follow synchronized pin");

   // Rising edge sets the rose flag
   AST_ROSE_SET: assert property ((sync2_q && !prev_q) |=> rose_q)
      else $error("rose flag not set by rising edge");

   // Falling edge sets the fell flag
   AST_FELL_SET: assert property ((!sync2_q && prev_q) |=> fell_q)
      else $error("fell flag not set by falling edge");

   // Rose flag clears only by full refresh
   AST_FLAG_CLEAR: assert property ((rose_q && !FULL_REFRESH) |=> rose_q)
      else $error("rose flag dropped without full refresh");

   // Full refresh clears fell flag when no new fall
   AST_FELL_CLEAR: assert property ((FULL_REFRESH && !fall_ev) |=> !fell_q)
      else $error("fell flag not cleared by full refresh");

   // Enables hold unless written
   AST_EN_HOLD: assert property (!mon_wr |=> (edge_en_q == $past(edge_en_q)))
      else $error("edge enables changed without a write");

   // Rising edge with full enable clears accumulators
   AST_RISE_FULL: assert property ((rise_ev && edge_en_q[RISE_FULL_EN_BIT-1]) |=> (ACCUM_CLEAR && SNAPSHOT))
      else $error("rising full refresh missing");

   // Fall with only keep enabled snapshots without clear
   AST_FALL_KEEP: assert property ((fall_ev && edge_en_q[FALL_KEEP_EN_BIT-1] && !edge_en_q[FALL_FULL_EN_BIT-1]
      && !FULL_REFRESH) |=> (SNAPSHOT && !ACCUM_CLEAR && !LATCH_CONTROLS))
      else $error("falling keep refresh wrong");

   // Keep command snapshots and leaves accumulators
   AST_KEEP_CMD: assert property ((keep_cmd && !FULL_REFRESH && !lim_full) |=> (SNAPSHOT && !ACCUM_CLEAR))
      else $error("keep refresh command mishandled");

   // Data-bearing keep code alone does nothing
   AST_SEND_BYTE: assert property ((CMD.valid && CMD.has_data && !FULL_REFRESH && !rise_ev && !fall_ev
      && CMD.code == REFRESH_KEEP_ACCUM_CMD_OFS) |=> !SNAPSHOT)
      else $error("keep code with data was accepted");

   // Held results stable without a refresh
   AST_HOLD: assert property (!snap_now |=> (HELD_RESULTS == $past(HELD_RESULTS)))
      else $error("held results changed without refresh");

   // Bit 0 always reads zero
   AST_BIT0: assert property (RD_DATA[UNUSED_BIT] == 1'b0)
      else $error("unused bit reads one");

   // Reset leaves the monitor register cleared
   AST_RESET: assert property (disable iff (1'b0) RESET |=> (edge_en_q == 4'h0 && !rose_q && !fell_q))
      else $error("monitor register not cleared by reset");

   // Rise with only keep enabled snapshots without clear
   AST_RISE_KEEP: assert property ((rise_ev && edge_en_q[RISE_KEEP_EN_BIT-1] && !edge_en_q[RISE_FULL_EN_BIT-1]
      && !FULL_REFRESH) |=> (SNAPSHOT && !ACCUM_CLEAR && !LATCH_CONTROLS))
      else $error("rising keep refresh wrong");

   // Falling edge with full enable clears accumulators
   AST_FALL_FULL: assert property ((fall_ev && edge_en_q[FALL_FULL_EN_BIT-1]) |=> (ACCUM_CLEAR && SNAPSHOT))
      else $error("falling full refresh missing");

   // Rise with both rise enables off starts no refresh
   AST_RISE_OFF: assert property ((rise_ev && !edge_en_q[RISE_FULL_EN_BIT-1] && !edge_en_q[RISE_KEEP_EN_BIT-1]
      && !FULL_REFRESH && !keep_cmd) |=> !SNAPSHOT)
      else $error("rising edge refreshed while disabled");

   // Both rise enables set: full refresh with clear
   AST_BOTH_FULL: assert property ((rise_ev && edge_en_q[RISE_FULL_EN_BIT-1] && edge_en_q[RISE_KEEP_EN_BIT-1])
      |=> (SNAPSHOT && ACCUM_CLEAR))
      else $error("full refresh did not win on rising edge");

   // Controls latch only on a full command
   AST_NO_LATCH: assert property (!FULL_REFRESH |=> !LATCH_CONTROLS)
      else $error("controls latched by limited refresh");

   // Accumulators clear only on full refreshes
   AST_KEEP_NO_CLEAR: assert property ((!FULL_REFRESH && !lim_full) |=> !ACCUM_CLEAR)
      else $error("accumulators cleared by keep refresh");

   // Full refresh raises all three strobes
   AST_FULL_PULSES: assert property (FULL_REFRESH |=> (SNAPSHOT && ACCUM_CLEAR && LATCH_CONTROLS))
      else $error("full refresh strobes missing");

   // Full refresh captures the live results
   AST_FULL_CAPTURE: assert property (FULL_REFRESH |=> (HELD_RESULTS == $past(LIVE_RESULTS)))
      else $error("full refresh did not capture results");

   // Monitor read returns the live register view
   AST_READ_LIVE: assert property ((RD_ADDR == RATE_PIN_MONITOR_OFS) |=> (RD_DATA == $past(mon_value)))
      else $error("monitor read data not current");

   // Other addresses read as zero
   AST_READ_OTHER: assert property ((RD_ADDR != RATE_PIN_MONITOR_OFS) |=> (RD_DATA == READ_DATA_RESET))
      else $error("unmapped address read nonzero");

   // Any refresh drops the results valid flag
   AST_VALID_LOW: assert property (snap_now |=> !RESULTS_VALID)
      else $error("results valid during settle time");

   COV_FULL: cover property (FULL_REFRESH);
   COV_RISE_FULL: cover property (rise_ev && lim_full);
   COV_FALL_KEEP: cover property (fall_ev && lim_keep);
   COV_BOTH_EN: cover property (rise_ev && edge_en_q[RISE_FULL_EN_BIT-1] && edge_en_q[RISE_KEEP_EN_BIT-1]);
   COV_VALID: cover property (keep_cmd ##1 !snap_now [*3]);

endmodule // refresh_rate_monitor

//--- logic/refresh_monitor_pkg.sv
package refresh_monitor_pkg;

   // ----------------------------------------------------------------
   // Command codes and register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REFRESH_KEEP_ACCUM_CMD_OFS = 8'h1F;
   localparam logic [7:0] RATE_PIN_MONITOR_OFS = 8'h20;

   // ----------------------------------------------------------------
   // Monitor register field positions
   // ----------------------------------------------------------------
   localparam int PIN_LEVEL_BIT = 7;
   localparam int PIN_ROSE_FLAG_BIT = 6;
   localparam int PIN_FELL_FLAG_BIT = 5;
   localparam int RISE_FULL_EN_BIT = 4;
   localparam int RISE_KEEP_EN_BIT = 3;
   localparam int FALL_FULL_EN_BIT = 2;
   localparam int FALL_KEEP_EN_BIT = 1;
   localparam int UNUSED_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] EDGE_EN_RESET = 4'h0;
   localparam logic PIN_FLAG_RESET = 1'b0;
   localparam logic [7:0] READ_DATA_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Timing: results settle time after any refresh
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int RESULT_SETTLE_NS = 1000000;
   localparam int RESULT_SETTLE_CYCLES = (RESULT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Result widths and carriers
   // ----------------------------------------------------------------
   localparam int ACCUM_W = 56;
   localparam int COUNT_W = 32;
   localparam int VBUS_W = 16;
   localparam int VSENSE_W = 16;

   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic has_data;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed {
      logic [ACCUM_W-1:0] accum;
      logic [COUNT_W-1:0] count;
      logic [VBUS_W-1:0] vbus;
      logic [VSENSE_W-1:0] vsense;
   } results_t;

endpackage

//--- bench/host_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Host controller: issues commands and refreshes, reads back
// ------------------------------------------------------------
module host_model (
   input wire logic SYS_CLK,
   output refresh_monitor_pkg::cmd_t CMD,
   output logic FULL_REFRESH,
   output logic [7:0] RD_ADDR,
   input wire logic [7:0] RD_DATA,
   input wire logic RESULTS_VALID
);
   import refresh_monitor_pkg::*;

   // Idle bus from time zero
   initial begin
      CMD = '0;
      FULL_REFRESH = 1'b0;
      RD_ADDR = 8'h00;
   end

   // One decoded command, valid for exactly one cycle
   task automatic send(input logic [7:0] code, input logic has, input logic [7:0] data);
      @(posedge SYS_CLK);
      CMD <= '{valid: 1'b1, code: code, has_data: has, data: data};
      @(posedge SYS_CLK);
      CMD <= '0;
   endtask

   // Full refresh pulse
   task automatic full();
      @(posedge SYS_CLK);
      FULL_REFRESH <= 1'b1;
      @(posedge SYS_CLK);
      FULL_REFRESH <= 1'b0;
   endtask

   // Register read: pointer sampled, data valid after that edge
   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge SYS_CLK);
      RD_ADDR <= addr;
      @(posedge SYS_CLK);
      #1;
      data = RD_DATA;
   endtask

   // Wait up to 16 cycles for the settle time to pass and results to turn valid
   task automatic wait_valid(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 16 && !ok; i++) begin
         @(posedge SYS_CLK);
         #1;
         ok = (RESULTS_VALID === 1'b1);
      end
   endtask
endmodule // host_model

//--- bench/tb_refresh_rate_monitor.sv
`timescale 1ns/100ps

module tb_refresh_rate_monitor;
   import refresh_monitor_pkg::*;
   localparam int SETTLE = 8;
   logic SYS_CLK = 1'b0;
   logic RESET = 1'b1;
   logic RATE_PIN = 1'b0;
   cmd_t CMD;
   logic FULL_REFRESH;
   logic [7:0] RD_ADDR;
   logic [7:0] RD_DATA;
   results_t LIVE_RESULTS = '0;
   results_t HELD_RESULTS;
   logic RESULTS_VALID, SNAPSHOT, ACCUM_CLEAR, LATCH_CONTROLS;
   int fails = 0;
   int n_checks = 0;

   // ------------------------------------------------------------
   // Clock, design and host
   // ------------------------------------------------------------
   always #10 SYS_CLK = ~SYS_CLK;

   refresh_rate_monitor #(.SETTLE_CYCLES(SETTLE)) i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .RATE_PIN(RATE_PIN),
      .CMD(CMD), .FULL_REFRESH(FULL_REFRESH), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA), .LIVE_RESULTS(LIVE_RESULTS),
      .HELD_RESULTS(HELD_RESULTS), .RESULTS_VALID(RESULTS_VALID), .SNAPSHOT(SNAPSHOT), .ACCUM_CLEAR(ACCUM_CLEAR),
      .LATCH_CONTROLS(LATCH_CONTROLS));

   host_model i_host (.SYS_CLK(SYS_CLK), .CMD(CMD), .FULL_REFRESH(FULL_REFRESH), .RD_ADDR(RD_ADDR),
      .RD_DATA(RD_DATA), .RESULTS_VALID(RESULTS_VALID));

   // ------------------------------------------------------------
   // Compare tasks
   // ------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chkr(input results_t got, input results_t exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Pulses as {snapshot, clear, latch}
   task automatic pulses(input logic [2:0] exp);
      chk8({5'h00, SNAPSHOT, ACCUM_CLEAR, LATCH_CONTROLS}, {5'h00, exp});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] d;
      i_host.read(8'h20, d);
      chk8(d, 8'h00);
      i_host.read(8'h21, d);
      chk8(d, 8'h00);
      chk8({7'h00, RESULTS_VALID}, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_keep();
      results_t v;
      logic ok;
      v = {56'h12_3456_789A_BCDE, 32'hCAFE_0001, 16'h1234, 16'h8765};
      @(posedge SYS_CLK);
      LIVE_RESULTS <= v;
      i_host.send(8'h1F, 1'b1, 8'h5A);
      #1;
      pulses(3'b000);
      i_host.send(8'h1F, 1'b0, 8'h00);
      #1;
      pulses(3'b100);
      chkr(HELD_RESULTS, v);
      chk8({7'h00, RESULTS_VALID}, 8'h00);
      @(posedge SYS_CLK);
      LIVE_RESULTS <= ~v;
      i_host.wait_valid(ok);
      chk8({7'h00, ok}, 8'h01);
      chkr(HELD_RESULTS, v);
      $display("test keep refresh done");
   endtask

   task automatic t_write();
      logic [7:0] d;
      i_host.send(8'h20, 1'b1, 8'hFF);
      i_host.read(8'h20, d);
      chk8(d, 8'h1E);
      i_host.send(8'h20, 1'b1, 8'h00);
      i_host.read(8'h20, d);
      chk8(d, 8'h00);
      $display("test write done");
   endtask

   // Pin change, then the one pulse and the level bit
   task automatic pin_step(input logic lvl, input logic s, input logic c);
      logic [7:0] d;
      results_t h;
      results_t w;
      h = HELD_RESULTS;
      w = ~LIVE_RESULTS;
      @(posedge SYS_CLK);
      RATE_PIN <= lvl;
      LIVE_RESULTS <= w;
      repeat (3) @(posedge SYS_CLK);
      #1;
      pulses({s, c, 1'b0});
      chkr(HELD_RESULTS, s ? w : h);
      @(posedge SYS_CLK);
      #1;
      pulses(3'b000);
      i_host.read(8'h20, d);
      chk8({7'h00, d[7]}, {7'h00, lvl});
   endtask

   task automatic t_edges();
      logic [7:0] tbl [4];
      logic [7:0] d;
      tbl = '{8'h00, 8'h12, 8'h0C, 8'h1E};
      foreach (tbl[i]) begin
         i_host.send(8'h20, 1'b1, tbl[i]);
         pin_step(1'b1, tbl[i][4] | tbl[i][3], tbl[i][4]);
         pin_step(1'b0, tbl[i][2] | tbl[i][1], tbl[i][2]);
         i_host.read(8'h20, d);
         chk8(d, {3'b011, tbl[i][4:1], 1'b0});
      end
      @(posedge SYS_CLK);
      LIVE_RESULTS <= ~LIVE_RESULTS;
      i_host.full();
      #1;
      pulses(3'b111);
      chkr(HELD_RESULTS, LIVE_RESULTS);
      i_host.read(8'h20, d);
      chk8(d, 8'h1E);
      $display("test pin edges done");
   endtask

   // ------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (5) @(posedge SYS_CLK);
      RESET <= 1'b0;
      t_reset();
      t_keep();
      t_write();
      t_edges();
      report_and_stop();
   end

   // Watchdog, far beyond the expected hundred or so cycles
   initial begin
      #100_000;
      fails++;
      report_and_stop();
   end
endmodule // tb_refresh_rate_monitor
